//--- core/adsp_core.sv
// serial host port, output framing and configuration decoder
// assumes the modulator/filter pushes one result per start pulse,
// and that the bench resolves the sck and sdo wires from the enables
//
// Function
// (R1) overrange clamps code to plus full scale+1
// (R2) underrange clamps code to minus full scale-1
// (R3) next output bit follows falling serial clock
// (R4) strap low: clock input; high: device drives
// (R5) chip select high: data output released
// (R6) select low outside output: show busy flag
// (R7) sleep until rising clock with select low
// (R8) select rising in output aborts, starts conversion
// (R9) result shifted out most significant bit first
// (R10) power-up: channels 0/1, ratio 256, single
// (R11) each conversion end enters sleep state
// (R12) prefix 101 updates; 000/100 keep settings
// (R13) host sends only prefixes 101, 100, 000
// (R14) five channel bits then five speed bits
// (R15) ratio bits zero keep previous speed
// (R16) first address bit picks single-ended input
// (R17) differential pairs 2k and 2k+1, polarity
// (R18) single-ended: channel 2*addr+polarity against common
// (R19) eight-channel variant keeps top address zero
// (R20) ratio codes 1-9 give 64..16384, 15:32768
// (R21) double-rate bit selects doubled output rate
// (R22) host shifts input only during output
// (R23) frame: done, dummy, sign, result, sub bits
// (R24) sign and msb equal flag out of range
// (R25) 32nd falling edge starts a conversion
// (R26) fewer than 13 bits: settings unchanged
// (R27) ratio codes 10-14 keep previous speed
`timescale 1ns/1ps

// ******************************************************************
// result fifo
// ******************************************************************
module adsp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  // full and empty come straight from the count
  assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and count updates
  always_comb begin
    nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = AW'(0) + cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  // storage has no reset; only the pointers and the count need one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end
endmodule

// ******************************************************************
// serial port and configuration decoder
// ******************************************************************
module adsp_core (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // serial link pins
  input  wire logic        clock_source_strap_i,
  input  wire logic        sck_in_i,
  output logic             sck_out_o,
  output logic             sck_oe_o,
  input  wire logic        cs_n_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic             busy_o,
  // conversion engine
  output logic             conv_start_o,
  input  wire logic        conv_valid_i,
  output logic             conv_ready_o,
  input  wire logic [29:0] conv_value_i,
  input  wire logic        conv_over_i,
  input  wire logic        conv_under_i,
  // configuration for the running conversion
  output logic [3:0]       pos_chan_o,
  output logic [3:0]       neg_chan_o,
  output logic             neg_common_o,
  output logic [15:0]      oversampling_ratio_o,
  output logic             double_rate_select_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // ratio code to oversampling ratio
  function automatic logic [15:0] ratio_of(input logic [3:0] code);
    logic [15:0] r;
    r = 16'h0000;
    // (R20) ratio code table
    if (code == adsp_pkg::RAT_TOP) begin
      r = adsp_pkg::OSR_TOP;
    end else if (code >= adsp_pkg::RAT_FIRST &&
                 code <= adsp_pkg::RAT_LAST) begin
      r = 16'h0001 << (code + 4'(adsp_pkg::OSR_SHIFT));
    end
    return r;
  endfunction

  // ratio code that changes the speed setting
  function automatic logic ratio_valid(input logic [3:0] code);
    // (R15) (R27) zero and unlisted codes keep
    return ratio_of(code) != 16'h0000;
  endfunction

  // result word to output frame
  function automatic logic [31:0] fmt_frame(input logic [31:0] w);
    logic [31:0] f;
    f = 32'h0000_0000;
    // (R23) done and dummy low, sign inverted
    f[adsp_pkg::SIGN_POS:0] = {~w[29], w[28:0]};
    if (w[31]) begin
      // (R1) (R24) plus full scale+1
      f[adsp_pkg::SIGN_POS:0] = 30'h3000_0000;
    end else if (w[30]) begin
      // (R2) (R24) minus full scale-1
      f[adsp_pkg::SIGN_POS:0] = 30'h0FFF_FFFF;
    end
    return f;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] sck_s_ff, cs_s_ff, sdi_s_ff, strap_s_ff;
  logic       sck_d_ff, cs_d_ff;
  logic       sck_lvl;  // level of whichever clock is followed

  // every pin passes two flops before use
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sck_s_ff   <= 2'h0;
      cs_s_ff    <= 2'h3;
      sdi_s_ff   <= 2'h0;
      strap_s_ff <= 2'h0;
      sck_d_ff   <= 1'b0;
      cs_d_ff    <= 1'b1;
    end else begin
      sck_s_ff   <= {sck_s_ff[0], sck_in_i};
      cs_s_ff    <= {cs_s_ff[0], cs_n_i};
      sdi_s_ff   <= {sdi_s_ff[0], sdi_i};
      strap_s_ff <= {strap_s_ff[0], clock_source_strap_i};
      sck_d_ff   <= sck_lvl;
      cs_d_ff    <= cs_s_ff[1];
    end
  end

  // ****************************************************************
  // port state machine
  // ****************************************************************
  adsp_pkg::adsp_state_t state_ff, nxt_state;
  logic [31:0] sh_ff, nxt_sh;
  logic [12:0] in_ff, nxt_in;
  logic [5:0]  fall_ff, nxt_fall;
  logic [3:0]  rise_ff, nxt_rise;
  logic [2:0]  div_ff, nxt_div;
  logic        isck_ff, nxt_isck;
  logic        sdo_ff, nxt_sdo;
  logic        start_ff, nxt_start;
  logic        sgl_ff, nxt_sgl, odd_ff, nxt_odd, dbl_ff, nxt_dbl;
  logic [2:0]  addr_ff, nxt_addr;
  logic [3:0]  rat_ff, nxt_rat;
  logic        rise, fall, cs_low, cs_rise, ext_clk;
  logic        pop_ready, pop_valid, restart, apply;
  logic [31:0] pop_data;

  // (R4) strap selects which clock is followed
  assign ext_clk   = ~strap_s_ff[1];
  assign sck_lvl   = ext_clk ? sck_s_ff[1] : isck_ff;
  assign rise      = sck_lvl & ~sck_d_ff;
  assign fall      = ~sck_lvl & sck_d_ff;
  assign cs_low    = ~cs_s_ff[1];
  assign cs_rise   = cs_s_ff[1] & ~cs_d_ff;
  assign pop_ready = (state_ff == adsp_pkg::ST_CONV) & ~start_ff;

  // next state of the port, frame shifter and settings
  always_comb begin
    nxt_state = state_ff;
    nxt_sh    = sh_ff;
    nxt_in    = in_ff;
    nxt_fall  = fall_ff;
    nxt_rise  = rise_ff;
    nxt_div   = div_ff;
    nxt_isck  = isck_ff;
    nxt_start = 1'b0;
    nxt_sgl   = sgl_ff;
    nxt_odd   = odd_ff;
    nxt_addr  = addr_ff;
    nxt_rat   = rat_ff;
    nxt_dbl   = dbl_ff;
    restart   = 1'b0;
    case (state_ff)
      adsp_pkg::ST_CONV: begin
        // (R11) result arrives: hold it and sleep
        if (pop_valid & pop_ready) begin
          nxt_sh    = fmt_frame(pop_data);
          nxt_state = adsp_pkg::ST_SLEEP;
        end
      end
      adsp_pkg::ST_SLEEP: begin
        // (R7) first rising edge with select low
        if (rise & cs_low) begin
          nxt_state = adsp_pkg::ST_DOUT;
          nxt_in    = {in_ff[11:0], sdi_s_ff[1]};
          nxt_rise  = 4'h1;
          nxt_fall  = 6'h00;
        end
      end
      adsp_pkg::ST_DOUT: begin
        if (cs_rise) begin
          // (R8) abort and start over
          restart = 1'b1;
        end else begin
          // (R22) input sampled on rising edges here and on the waking edge in sleep
          if (rise && rise_ff != 4'(adsp_pkg::IN_BITS)) begin
            nxt_in   = {in_ff[11:0], sdi_s_ff[1]};
            nxt_rise = rise_ff + 4'h1;
          end
          if (fall) begin
            // (R3) (R9) next bit after each falling edge
            nxt_sh   = {sh_ff[30:0], 1'b0};
            nxt_fall = fall_ff + 6'h01;
            // (R25) 32nd falling edge ends the frame
            if (fall_ff == 6'(adsp_pkg::FRAME_BITS - 1)) begin
              restart = 1'b1;
            end
          end
        end
      end
      default: begin
        nxt_state = adsp_pkg::ST_CONV;
      end
    endcase
    // (R26) (R12) only a full 101 word is applied
    apply = restart && rise_ff == 4'(adsp_pkg::IN_BITS) &&
            in_ff[adsp_pkg::CMD_MSB -: 3] == adsp_pkg::CMD_UPDATE;
    if (restart) begin
      nxt_state = adsp_pkg::ST_CONV;
      nxt_start = 1'b1;
      nxt_rise  = 4'h0;
      nxt_isck  = 1'b0;
      nxt_div   = 3'h0;
    end
    if (apply) begin
      // (R14) (R16) channel word
      nxt_sgl  = in_ff[adsp_pkg::SGL_POS];
      nxt_odd  = in_ff[adsp_pkg::ODD_POS];
      nxt_addr = in_ff[adsp_pkg::ADDR_MSB -: 3];
      // (R15) (R27) speed kept on zero or unlisted codes
      if (ratio_valid(in_ff[adsp_pkg::RAT_MSB -: 4])) begin
        nxt_rat = in_ff[adsp_pkg::RAT_MSB -: 4];
        nxt_dbl = in_ff[adsp_pkg::DBL_POS];
      end
    end
    // (R4) internal clock runs only for an open frame
    if (~ext_clk && cs_low && !restart &&
        (state_ff == adsp_pkg::ST_SLEEP ||
         state_ff == adsp_pkg::ST_DOUT)) begin
      if (div_ff == 3'(adsp_pkg::SCK_HALF_CYC - 1)) begin
        nxt_div  = 3'h0;
        nxt_isck = ~isck_ff;
      end else begin
        nxt_div = div_ff + 3'h1;
      end
    end
    // (R6) busy flag outside the output state
    case (nxt_state)
      adsp_pkg::ST_CONV:  nxt_sdo = 1'b1;
      adsp_pkg::ST_SLEEP: nxt_sdo = 1'b0;
      default:            nxt_sdo = nxt_sh[adsp_pkg::DONE_POS];
    endcase
  end

  // (R10) power-up starts a default conversion
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= adsp_pkg::ST_CONV;
      sh_ff    <= 32'h0000_0000;
      in_ff    <= 13'h0000;
      fall_ff  <= 6'h00;
      rise_ff  <= 4'h0;
      div_ff   <= 3'h0;
      isck_ff  <= 1'b0;
      sdo_ff   <= 1'b1;
      start_ff <= 1'b1;
      sgl_ff   <= adsp_pkg::RST_SGL;
      odd_ff   <= adsp_pkg::RST_ODD;
      addr_ff  <= adsp_pkg::RST_ADDR;
      rat_ff   <= adsp_pkg::RST_RATIO;
      dbl_ff   <= adsp_pkg::RST_DBL;
    end else begin
      state_ff <= nxt_state;
      sh_ff    <= nxt_sh;
      in_ff    <= nxt_in;
      fall_ff  <= nxt_fall;
      rise_ff  <= nxt_rise;
      div_ff   <= nxt_div;
      isck_ff  <= nxt_isck;
      sdo_ff   <= nxt_sdo;
      start_ff <= nxt_start;
      sgl_ff   <= nxt_sgl;
      odd_ff   <= nxt_odd;
      addr_ff  <= nxt_addr;
      rat_ff   <= nxt_rat;
      dbl_ff   <= nxt_dbl;
    end
  end

  // ****************************************************************
  // result buffer
  // ****************************************************************
  // engine stalls when sixteen results wait unread
  adsp_fifo #(
    .WIDTH (adsp_pkg::FIFO_WIDTH),
    .DEPTH (adsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (conv_valid_i),
    .in_ready_o  (conv_ready_o),
    .in_data_i   ({conv_over_i, conv_under_i, conv_value_i}),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // (R5) data pin released while select is high
  assign sdo_o     = sdo_ff;
  assign sdo_oe_o  = cs_low;
  assign sck_out_o = isck_ff;
  assign sck_oe_o  = ~ext_clk;
  assign busy_o    = (state_ff == adsp_pkg::ST_CONV);
  assign conv_start_o = start_ff;

  // (R16) (R17) (R18) (R19) multiplexer decode
  always_comb begin
    logic [2:0] a;
    a = addr_ff;
    if (adsp_pkg::EIGHT_CH_VARIANT) begin
      a[2] = 1'b0;
    end
    pos_chan_o   = {a, odd_ff};
    neg_chan_o   = {a, ~odd_ff};
    neg_common_o = sgl_ff;
  end
  assign oversampling_ratio_o = ratio_of(rat_ff);
  // (R21) speed mode passed to the engine
  assign double_rate_select_o = dbl_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_frame_end;
    state_ff == adsp_pkg::ST_DOUT && !cs_rise && fall &&
    fall_ff == 6'(adsp_pkg::FRAME_BITS - 1);
  endsequence

  sequence s_new_conv;
    state_ff == adsp_pkg::ST_CONV && start_ff && sdo_ff;
  endsequence

  sdo_release_a: assert property ( // (R5)
    sdo_oe_o == ~cs_s_ff[1])
    else $error("data output enable does not follow select");
  busy_flag_a: assert property ( // (R6)
    state_ff != adsp_pkg::ST_DOUT |-> sdo_ff == busy_o)
    else $error("busy flag wrong on data output");
  frame_end_a: assert property ( // (R25)
    s_frame_end |=> s_new_conv)
    else $error("no conversion after last falling edge");
  abort_start_a: assert property ( // (R8)
    state_ff == adsp_pkg::ST_DOUT && cs_rise |=> s_new_conv)
    else $error("select rise did not abort");
  sleep_wake_a: assert property ( // (R7)
    state_ff == adsp_pkg::ST_SLEEP && !(rise && cs_low)
    |=> state_ff == adsp_pkg::ST_SLEEP)
    else $error("left sleep without a clock edge");
  bit_shift_a: assert property ( // (R3)
    state_ff == adsp_pkg::ST_DOUT && fall && !cs_rise &&
    fall_ff < 6'(adsp_pkg::FRAME_BITS - 1)
    |=> sdo_o == $past(sh_ff[30]))
    else $error("output bit not advanced on falling edge");
  short_keep_a: assert property ( // (R26)
    restart && rise_ff != 4'(adsp_pkg::IN_BITS) |=> $stable(addr_ff)
    && $stable(rat_ff) && $stable(sgl_ff))
    else $error("partial input changed settings");
  speed_keep_a: assert property ( // (R15)
    apply && !ratio_valid(in_ff[adsp_pkg::RAT_MSB -: 4])
    |=> $stable(rat_ff) && $stable(dbl_ff))
    else $error("speed changed on keep code");
  sleep_entry_a: assert property ( // (R11)
    state_ff == adsp_pkg::ST_CONV && pop_valid && pop_ready
    |=> state_ff == adsp_pkg::ST_SLEEP && !sdo_ff)
    else $error("conversion end did not enter sleep");

endmodule

//--- core/adsp_pkg.sv
// constants of the converter serial port and configuration decoder
// assumes a single 50 MHz clock and a synchronous active-high reset
package adsp_pkg;

  // ****************************************************************
  // clock and link timing
  // ****************************************************************
  localparam int CLK_NS       = 20;   // system clock period
  localparam int SCK_HALF_NS  = 80;   // half period of generated clock
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int FRAME_BITS  = 32;
  localparam int DONE_POS    = 31;
  localparam int DUMMY_POS   = 30;
  localparam int SIGN_POS    = 29;
  localparam int RES_MSB_POS = 28;
  localparam int IN_BITS     = 13;    // command, channel and speed bits
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_WIDTH  = 32;    // {over, under, value[29:0]}

  // ****************************************************************
  // command prefixes and input stream fields
  // ****************************************************************
  localparam logic [2:0] CMD_UPDATE = 3'h5;  // 101
  localparam int CMD_MSB  = 12;
  localparam int SGL_POS  = 9;
  localparam int ODD_POS  = 8;
  localparam int ADDR_MSB = 7;
  localparam int RAT_MSB  = 4;
  localparam int DBL_POS  = 0;

  // ****************************************************************
  // reset configuration and ratio codes
  // ****************************************************************
  localparam logic       RST_SGL   = 1'b0;
  localparam logic       RST_ODD   = 1'b0;
  localparam logic [2:0] RST_ADDR  = 3'h0;
  localparam logic [3:0] RST_RATIO = 4'h3;   // ratio 256
  localparam logic       RST_DBL   = 1'b0;
  localparam logic [3:0] RAT_FIRST = 4'h1;
  localparam logic [3:0] RAT_LAST  = 4'h9;
  localparam logic [3:0] RAT_TOP   = 4'hF;
  localparam logic [15:0] OSR_TOP  = 16'h8000;
  localparam int          OSR_SHIFT = 5;    // code 1 gives 64
  localparam logic        EIGHT_CH_VARIANT = 1'b0;

  // ****************************************************************
  // port states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_CONV  = 2'b00,
    ST_SLEEP = 2'b01,
    ST_DOUT  = 2'b10
  } adsp_state_t;

endpackage

//--- bench/adsp_host_model.sv
// host side model: serial master with its own serial clock
// assumes the bench resolves the sck and sdo wires from the enables
`timescale 1ns/1ps

module adsp_host_model (
  // clock
  input  wire logic clk_i,
  // link pins
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  int unsteady;  // bits that moved during a high half

  // idle link: clock stands low, chip deselected
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    unsteady = 0;
  end

  // ***********************************************
  // serial cycles, 160 ns each, driven at falling clk
  // ***********************************************
  // one clock cycle: data set in low half, read late in high half
  task automatic pulse(input logic d, output logic q);
    logic s1;
    sdi_o = d;
    repeat (4) @(negedge clk_i);
    sck_o = 1'b1;
    repeat (2) @(negedge clk_i);
    s1 = sdo_i;
    repeat (2) @(negedge clk_i);
    q = sdo_i;
    if (s1 !== q) unsteady++;
    sck_o = 1'b0;
  endtask

  task automatic set_cs(input logic lvl);
    @(negedge clk_i);
    cs_n_o = lvl;
    repeat (4) @(negedge clk_i);
  endtask

  // word msb first, only inside a frame
  task automatic frame(input logic [12:0] cfg, input int nb,
                       output logic [31:0] rx);
    logic q;
    rx = '0;
    set_cs(1'b0);
    for (int i = 0; i < nb; i++) begin
      pulse((i < 13) ? cfg[12-i] : 1'b0, q);
      rx = {rx[30:0], q};
    end
    sdi_o = 1'b0;
    if (nb < 32) cs_n_o = 1'b1;
  endtask
endmodule

//--- bench/adsp_core_test.sv
// self-checking bench of the serial port and configuration decoder
// assumes the host model file; the bench plays the conversion engine
`timescale 1ns/1ps

module adsp_core_test;
  // ***********************************************
  // signals and instances
  // ***********************************************
  logic        clk, rst, strap, hsck, cs_n, sdi, sck_w, sdo_w;
  logic        sck_out, sck_oe, sdo, sdo_oe, busy, ready, sdo_last;
  logic        ev, eo, eu, took, common_input, dbl, sck_prev, start;
  logic        e_sgl, e_odd, e_dbl;
  logic [2:0]  e_addr;
  logic [3:0]  pos, neg;
  logic [15:0] oversampling_ratio, e_osr;
  logic [29:0] ev_data;
  logic [31:0] rnd, rx, exp_q[$], eng_q[$];
  int          err_count, check_count, n, starts;

  // clock, 20 ns period
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // strap picks who drives the clock wire
  assign sck_w = sck_oe ? sck_out : hsck;
  // released data line shows the inverse of its last value
  assign sdo_w = sdo_oe ? sdo : ~sdo_last;
  always @(posedge clk) begin
    if (rst) sdo_last <= 1'b0;
    else if (sdo_oe) sdo_last <= sdo;
  end

  always @(posedge clk) begin
    if (rst) starts <= 0;
    else if (start) starts <= starts + 1;
  end

  adsp_core adsp_core_inst (
    .clk_i(clk), .reset_i(rst), .clock_source_strap_i(strap),
    .sck_in_i(sck_w), .sck_out_o(sck_out), .sck_oe_o(sck_oe),
    .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .busy_o(busy), .conv_start_o(start), .conv_valid_i(ev),
    .conv_ready_o(ready), .conv_value_i(ev_data), .conv_over_i(eo),
    .conv_under_i(eu), .pos_chan_o(pos), .neg_chan_o(neg),
    .neg_common_o(common_input), .oversampling_ratio_o(oversampling_ratio),
    .double_rate_select_o(dbl)
  );

  adsp_host_model adsp_host_model_inst (
    .clk_i(clk), .sdo_i(sdo_w), .sck_o(hsck), .cs_n_o(cs_n),
    .sdi_o(sdi)
  );

  // engine: a result stands until taken at a rising edge
  always @(posedge clk) took <= ev && ready;
  always @(negedge clk) begin
    if (took) void'(eng_q.pop_front());
    ev = (eng_q.size() > 0);
    {eo, eu, ev_data} = ev ? eng_q[0] : 32'h0;
  end

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] frame_of(input logic [31:0] e);
    if (e[31]) return 32'h3000_0000;
    if (e[30]) return 32'h0FFF_FFFF;
    return {2'b00, ~e[29], e[28:0]};
  endfunction

  // ratio from code, zero meaning keep
  function automatic logic [15:0] ratio_of(input logic [3:0] c);
    if (c == 4'hF) return 16'h8000;
    if (c >= 4'h1 && c <= 4'h9) return 16'h0020 << c;
    return 16'h0000;
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // bounded wait on the busy level; a hang ends the run
  task automatic wait_busy(input logic lvl);
    int k = 0;
    while (busy !== lvl && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (busy !== lvl) begin
      err_count++;
      $display("CHECK FAILED t=%0t busy=%h exp=%h", $time, busy, lvl);
      complete_run();
    end
  endtask

  task automatic check_cfg();
    check_word({28'h0, pos}, {28'h0, e_addr, e_odd});
    if (!e_sgl) check_word({28'h0, neg}, {28'h0, e_addr, ~e_odd});
    check_word({31'h0, common_input}, {31'h0, e_sgl});
    check_word({15'h0, dbl, oversampling_ratio}, {15'h0, e_dbl, e_osr});
  endtask

  // whole update word; keep codes keep rate bit
  task automatic apply(input logic [12:0] c, input int nb);
    if (nb < 13 || c[12:10] !== 3'h5) return;
    {e_sgl, e_odd, e_addr} = c[9:5];
    if (ratio_of(c[4:1]) != 16'h0) begin
      e_osr = ratio_of(c[4:1]);
      e_dbl = c[0];
    end
  endtask

  task automatic push_result();
    rnd = lfsr(rnd);
    eng_q.push_back({rnd[31:29] == 3'h7, rnd[31:29] == 3'h6, rnd[29:0]});
    exp_q.push_back(frame_of(eng_q[$]));
  endtask

  // ***********************************************
  // sequence
  // ***********************************************
  initial begin
    logic [12:0] c;
    logic [31:0] m;
    int nb;
    rnd = 32'h843D2F15;
    {strap, sck_prev} = 2'b00;
    rst = 1'b1;
    err_count = 0;
    check_count = 0;
    {e_sgl, e_odd, e_addr, e_dbl, e_osr} = {5'h00, 1'b0, 16'h0100};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check_word({31'h0, busy}, 32'h1);
    check_cfg();
    check_word({30'h0, sdo_oe, sck_oe}, 32'h0);
    adsp_host_model_inst.set_cs(1'b0);
    check_word({31'h0, sdo_w}, 32'h1);
    push_result();
    wait_busy(1'b0);
    repeat (4) @(negedge clk);
    check_word({31'h0, sdo_w}, 32'h0);
    adsp_host_model_inst.set_cs(1'b1);
    // sck with the chip deselected must not open a frame
    adsp_host_model_inst.pulse(1'b1, m[0]);
    adsp_host_model_inst.pulse(1'b1, m[0]);
    repeat (17) push_result();
    repeat (40) @(negedge clk);
    check_word({31'h0, ready}, 32'h0);
    check_word(32'(eng_q.size()), 32'h1);
    check_word(32'(starts), 32'h1);
    $display("test power_up_and_fill done");

    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      c = {(i < 16) ? 3'h5 : (i % 3 == 0) ? 3'h0 : (i % 3 == 1) ? 3'h4
           : 3'h5, rnd[12:8], i[3:0], rnd[13]};
      nb = (i == 17) ? 12 : (i == 20) ? 13 : (i == 22) ? 20 : 32;
      wait_busy(1'b0);
      adsp_host_model_inst.frame(c, nb, rx);
      apply(c, nb);
      m = 32'hFFFF_FFFF << (32 - nb);
      check_word(rx << (32 - nb), exp_q.pop_front() & m);
      wait_busy(1'b1);
      // busy may last only two cycles when results are queued
      if (nb == 32) check_word({31'h0, sdo_w}, 32'h1);
      repeat (4) @(negedge clk);
      check_cfg();
      adsp_host_model_inst.set_cs(1'b1);
      check_word({31'h0, sdo_oe}, 32'h0);
      push_result();
    end
    check_word(32'(starts), 32'd25);
    $display("test random_frames done");

    wait_busy(1'b0);
    strap = 1'b1;
    adsp_host_model_inst.set_cs(1'b0);
    n = 0;
    rx = '0;
    // count device clock edges until the restart
    for (int k = 0; k < 3000 && busy !== 1'b1; k++) begin
      @(negedge clk);
      if (sck_w && !sck_prev) rx = {rx[30:0], sdo_w};
      if (!sck_w && sck_prev) n++;
      sck_prev = sck_w;
    end
    wait_busy(1'b1);
    check_word({31'h0, sck_oe}, 32'h1);
    check_word(32'(n), 32'd32);
    check_word(rx, exp_q.pop_front());
    repeat (4) @(negedge clk);
    check_cfg();
    adsp_host_model_inst.set_cs(1'b1);
    strap = 1'b0;
    check_word(32'(adsp_host_model_inst.unsteady), 32'h0);
    $display("test internal_clock done");
    complete_run();
  end
endmodule
